//--- src/tsens_regs_pkg.sv
`default_nettype none
package tsens_regs_pkg;
   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [1:0]  IDX_TEMPERATURE = 2'h0;
   localparam logic [1:0]  IDX_SETTINGS    = 2'h1;
   localparam logic [1:0]  IDX_LOW_LIMIT   = 2'h2;
   localparam logic [1:0]  IDX_HIGH_LIMIT  = 2'h3;
   localparam int          POINTER_W       = 8;
   localparam int          INDEX_W         = 2;
   localparam int          REG_W           = 16;
   localparam logic [15:0] SETTINGS_RESET  = 16'h40A0;
   localparam logic [15:0] SETTINGS_WMASK  = 16'h9FC0;
   localparam logic [15:0] LOW_RESET       = 16'h0000;
   localparam logic [15:0] HIGH_RESET      = 16'h0000;
   localparam logic [15:0] TEMP_RESET      = 16'h0000;
   localparam int          RATE_LSB        = 6;
   // ****************************************************************
   // Conversion periods
   // ****************************************************************
   localparam longint      CLK_HZ          = 100_000_000;
   localparam longint      PERIOD_0_MS     = 4000;
   localparam longint      PERIOD_1_MS     = 1000;
   localparam longint      PERIOD_2_MS     = 250;
   localparam longint      PERIOD_3_MS     = 125;
   localparam longint      PERIOD_0_CYC    = PERIOD_0_MS * CLK_HZ / 1000;
   localparam longint      PERIOD_1_CYC    = PERIOD_1_MS * CLK_HZ / 1000;
   localparam longint      PERIOD_2_CYC    = PERIOD_2_MS * CLK_HZ / 1000;
   localparam longint      PERIOD_3_CYC    = PERIOD_3_MS * CLK_HZ / 1000;
   localparam longint      PERIOD_MAX_CYC  = 64'h0000_0001_0000_0000;
endpackage
`default_nettype wire

//--- src/tsens_regs.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Eight-bit pointer, low two bits hold index
// - Pointer bits 2 to 7 read zero
// - Accesses go to the indexed register
// - Index 0 temp, 1 settings, 2 low, 3 high
// - Temperature read-only, limits read-write, settings writable in SETTINGS_WMASK bits only
// - Registers reached over two-wire bus, temperature also loaded by converter
// - Sixteen-bit registers move high byte first
// - Conversion period selectable, 250 ms default
module tsens_regs #(
   parameter longint P0_CYC = tsens_regs_pkg::PERIOD_0_CYC,
   parameter longint P1_CYC = tsens_regs_pkg::PERIOD_1_CYC,
   parameter longint P2_CYC = tsens_regs_pkg::PERIOD_2_CYC,
   parameter longint P3_CYC = tsens_regs_pkg::PERIOD_3_CYC
) (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RESET,
   // Byte stream from the two-wire bus engine
   input  wire logic        WR_START,
   input  wire logic        WR_BYTE_VALID,
   input  wire logic [7:0]  WR_BYTE,
   input  wire logic        RD_START,
   input  wire logic        RD_BYTE_TAKE,
   output logic      [7:0]  RD_BYTE,
   // Converter side
   input  wire logic        RESULT_VALID,
   input  wire logic [15:0] RESULT_DATA,
   output logic             CONVERT_START,
   // Register contents
   output logic      [7:0]  POINTER,
   output logic      [15:0] SETTINGS,
   output logic      [15:0] LOW_LIMIT,
   output logic      [15:0] HIGH_LIMIT
);
   import tsens_regs_pkg::*;

   // The pacing counter is 32 bits wide, and a period under two cycles
   // would let conversion pulses run together
   if (P0_CYC < 2 || P1_CYC < 2 || P2_CYC < 2 || P3_CYC < 2 || P0_CYC > PERIOD_MAX_CYC ||
       P1_CYC > PERIOD_MAX_CYC || P2_CYC > PERIOD_MAX_CYC || P3_CYC > PERIOD_MAX_CYC) begin : g_bad
      $error("conversion period counts out of range");
   end

   typedef enum logic [1:0] {WS_IDLE, WS_POINTER, WS_HIGH, WS_LOW} wstate_e;

   // ****************************************************************
   // Register state
   // ****************************************************************
   wstate_e      ws_r, ws_nxt;
   logic [1:0]   idx_r, idx_nxt;
   logic [15:0]  temp_r, temp_nxt;
   logic [15:0]  set_r, set_nxt;
   logic [15:0]  low_r, low_nxt;
   logic [15:0]  high_r, high_nxt;
   logic [7:0]   wr_hi_r, wr_hi_nxt;
   logic         rd_lo_r, rd_lo_nxt;
   logic [7:0]   rd_r, rd_nxt;
   logic [31:0]  cnt_r, cnt_nxt;
   logic         conv_r, conv_nxt;

   function automatic logic [15:0] sel_reg(input logic [1:0] i, input logic [15:0] t,
                                           input logic [15:0] s, input logic [15:0] l,
                                           input logic [15:0] h);
      unique case (i)
         IDX_TEMPERATURE: sel_reg = t;
         IDX_SETTINGS:    sel_reg = s;
         IDX_LOW_LIMIT:   sel_reg = l;
         IDX_HIGH_LIMIT:  sel_reg = h;
      endcase
   endfunction

   function automatic logic [31:0] period(input logic [1:0] rate);
      unique case (rate)
         2'h0: period = 32'(P0_CYC - 1);
         2'h1: period = 32'(P1_CYC - 1);
         2'h2: period = 32'(P2_CYC - 1);
         2'h3: period = 32'(P3_CYC - 1);
      endcase
   endfunction

   logic [15:0] cur;
   logic [15:0] wdata;
   logic [1:0]  rate;

   always_comb begin
      cur       = sel_reg(idx_r, temp_r, set_r, low_r, high_r);
      wdata     = {wr_hi_r, WR_BYTE};
      rate      = set_r[RATE_LSB +: 2];
      ws_nxt    = ws_r;
      idx_nxt   = idx_r;
      temp_nxt  = temp_r;
      set_nxt   = set_r;
      low_nxt   = low_r;
      high_nxt  = high_r;
      wr_hi_nxt = wr_hi_r;
      rd_lo_nxt = rd_lo_r;
      rd_nxt    = rd_r;
      cnt_nxt   = cnt_r;
      conv_nxt  = 1'b0;
      // Write: first byte is pointer, then high byte, then low byte
      if (WR_START) begin
         ws_nxt = WS_POINTER;
      end else if (WR_BYTE_VALID) begin
         unique case (ws_r)
            WS_IDLE: ws_nxt = WS_IDLE;
            WS_POINTER: begin
               idx_nxt = WR_BYTE[INDEX_W-1:0];
               ws_nxt  = WS_HIGH;
            end
            WS_HIGH: begin
               wr_hi_nxt = WR_BYTE;
               ws_nxt    = WS_LOW;
            end
            WS_LOW: begin
               unique case (idx_r)
                  IDX_TEMPERATURE: ;
                  IDX_SETTINGS:
                     set_nxt = (set_r & ~SETTINGS_WMASK) | (wdata & SETTINGS_WMASK);
                  IDX_LOW_LIMIT:   low_nxt = wdata;
                  IDX_HIGH_LIMIT:  high_nxt = wdata;
               endcase
               ws_nxt = WS_HIGH;
            end
         endcase
      end
      // Read: high byte first, then low byte, alternating
      if (RD_START) begin
         rd_nxt    = cur[15:8];
         rd_lo_nxt = 1'b1;
      end else if (RD_BYTE_TAKE) begin
         rd_nxt    = rd_lo_r ? cur[7:0] : cur[15:8];
         rd_lo_nxt = ~rd_lo_r;
      end
      // Conversion pacing, sleep bit not modelled here
      if (cnt_r == 32'h0000_0000) begin
         cnt_nxt  = period(rate);
         conv_nxt = 1'b1;
      end else if (cnt_r > period(rate)) begin
         cnt_nxt = period(rate);
      end else begin
         cnt_nxt = cnt_r - 32'h0000_0001;
      end
      if (RESULT_VALID) begin
         temp_nxt = RESULT_DATA;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ws_r    <= WS_IDLE;
         idx_r   <= IDX_TEMPERATURE;
         temp_r  <= TEMP_RESET;
         set_r   <= SETTINGS_RESET;
         low_r   <= LOW_RESET;
         high_r  <= HIGH_RESET;
         wr_hi_r <= 8'h00;
         rd_lo_r <= 1'b0;
         rd_r    <= 8'h00;
         cnt_r   <= 32'h0000_0000;
         conv_r  <= 1'b0;
      end else begin
         ws_r    <= ws_nxt;
         idx_r   <= idx_nxt;
         temp_r  <= temp_nxt;
         set_r   <= set_nxt;
         low_r   <= low_nxt;
         high_r  <= high_nxt;
         wr_hi_r <= wr_hi_nxt;
         rd_lo_r <= rd_lo_nxt;
         rd_r    <= rd_nxt;
         cnt_r   <= cnt_nxt;
         conv_r  <= conv_nxt;
      end
   end

   assign POINTER       = {6'h00, idx_r};
   assign SETTINGS      = set_r;
   assign LOW_LIMIT     = low_r;
   assign HIGH_LIMIT    = high_r;
   assign RD_BYTE       = rd_r;
   assign CONVERT_START = conv_r;

   // ****************************************************************
   // Checks
   // ****************************************************************
   pointer_upper_a: assert property (@(posedge CLK) disable iff (RESET)
      POINTER[7:2] == 6'h00) else $error("pointer upper bits not zero");
   pointer_load_a: assert property (@(posedge CLK) disable iff (RESET)
      (WR_BYTE_VALID && !WR_START && ws_r == WS_POINTER) |=> idx_r == $past(WR_BYTE[1:0]))
      else $error("pointer not loaded");
   temp_ro_a: assert property (@(posedge CLK) disable iff (RESET)
      (WR_BYTE_VALID && !WR_START && ws_r == WS_LOW && idx_r == IDX_TEMPERATURE
       && !RESULT_VALID) |=> $stable(temp_r))
      else $error("temperature written by host");
   high_write_a: assert property (@(posedge CLK) disable iff (RESET)
      (WR_BYTE_VALID && !WR_START && ws_r == WS_LOW && idx_r == IDX_HIGH_LIMIT)
      |=> high_r == $past(wdata)) else $error("high limit write lost");
   settings_write_a: assert property (@(posedge CLK) disable iff (RESET)
      (WR_BYTE_VALID && !WR_START && ws_r == WS_LOW && idx_r == IDX_SETTINGS)
      |=> (SETTINGS & SETTINGS_WMASK) == ($past(wdata) & SETTINGS_WMASK))
      else $error("settings write lost");
   conv_period_a: assert property (@(posedge CLK) disable iff (RESET)
      (CONVERT_START && $stable(rate)) |-> cnt_r == period(rate))
      else $error("conversion period not reloaded");
   read_high_a: assert property (@(posedge CLK) disable iff (RESET)
      RD_START |=> RD_BYTE == $past(cur[15:8])) else $error("read not high byte first");
   read_low_a: assert property (@(posedge CLK) disable iff (RESET)
      (RD_START ##1 (RD_BYTE_TAKE && !RD_START && $stable(cur))) |=> RD_BYTE == $past(cur[7:0]))
      else $error("second read byte not low byte");
   low_write_a: assert property (@(posedge CLK) disable iff (RESET)
      (WR_BYTE_VALID && !WR_START && ws_r == WS_LOW && idx_r == IDX_LOW_LIMIT)
      |=> low_r == $past(wdata)) else $error("low limit write lost");
   conv_pace_a: assert property (@(posedge CLK) disable iff (RESET)
      (CONVERT_START && $stable(rate)) |=> !CONVERT_START) else $error("conversion too soon");
   reset_pointer_a: assert property (@(posedge CLK)
      $fell(RESET) |-> POINTER == 8'h00) else $error("pointer not zero after reset");
endmodule
`default_nettype wire

//--- sim/tsens_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsens_host_model (
   // Clock
   input  wire logic       CLK,
   // Byte stream toward the block
   output logic            WR_START,
   output logic            WR_BYTE_VALID,
   output logic [7:0]      WR_BYTE,
   output logic            RD_START,
   output logic            RD_BYTE_TAKE,
   input  wire logic [7:0] RD_BYTE
);
   // ****
   // Host transfers
   // ****
   initial begin
      {WR_START, WR_BYTE_VALID, RD_START, RD_BYTE_TAKE} = 4'h0;
      WR_BYTE = 8'h00;
   end
   task automatic put(input logic [7:0] b);
      @(posedge CLK);
      WR_START <= 1'b0;
      WR_BYTE_VALID <= 1'b1;
      WR_BYTE <= b;
   endtask
   task automatic wr(input logic [7:0] p, input logic [15:0] v, input bit data);
      @(posedge CLK);
      WR_START <= 1'b1;
      put(p);
      if (data) begin
         put(v[15:8]);
         put(v[7:0]);
      end
      @(posedge CLK);
      WR_BYTE_VALID <= 1'b0;
      // Stale byte is scrambled so it never passes for live data
      WR_BYTE <= ~WR_BYTE;
      // Let the register update of the last byte settle before the caller looks
      #1;
   endtask
   task automatic rd(output logic [15:0] v);
      @(posedge CLK);
      RD_START <= 1'b1;
      @(posedge CLK);
      RD_START <= 1'b0;
      RD_BYTE_TAKE <= 1'b1;
      #1 v[15:8] = RD_BYTE;
      @(posedge CLK);
      RD_BYTE_TAKE <= 1'b0;
      #1 v[7:0] = RD_BYTE;
   endtask
endmodule
`default_nettype wire

//--- sim/tsens_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tsens_regs_tb_top;
   import tsens_regs_pkg::*;
   logic        CLK, RESET, rv, ws, wv, rs, rt, conv;
   logic [7:0]  wb, rb, ptr;
   logic [15:0] rdat, sw, lo, hi, d;
   int          error_cnt, n_checks, n;
   tsens_regs #(.P0_CYC(40), .P1_CYC(20), .P2_CYC(10), .P3_CYC(5)) i_tsens_regs (
      .CLK(CLK), .RESET(RESET), .WR_START(ws), .WR_BYTE_VALID(wv), .WR_BYTE(wb),
      .RD_START(rs), .RD_BYTE_TAKE(rt), .RD_BYTE(rb), .RESULT_VALID(rv),
      .RESULT_DATA(rdat), .CONVERT_START(conv), .POINTER(ptr), .SETTINGS(sw),
      .LOW_LIMIT(lo), .HIGH_LIMIT(hi));
   tsens_host_model i_tsens_host_model (.CLK(CLK), .WR_START(ws), .WR_BYTE_VALID(wv),
      .WR_BYTE(wb), .RD_START(rs), .RD_BYTE_TAKE(rt), .RD_BYTE(rb));
   // ****
   // Helpers
   // ****
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Cycles up to the next conversion pulse, bounded
   task automatic gap(output int k);
      for (k = 1; k <= 100; k++) begin
         @(posedge CLK);
         #1;
         if (conv === 1'b1) return;
      end
      error_cnt++;
      $display("CHECK FAILED at %0t: no conversion pulse in time", $time);
      report_and_stop();
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_pointer();
      i_tsens_host_model.wr(8'hFE, 16'h0000, 1'b0);
      chk({8'h00, ptr}, 16'h0002);
      i_tsens_host_model.wr(8'h03, 16'h0000, 1'b0);
      chk({8'h00, ptr}, 16'h0003);
   endtask
   task automatic t_regs();
      logic [15:0] v[3];
      logic [15:0] e[3];
      v = '{16'hFFFF, 16'h8001, 16'h7FFE};
      e = '{(16'hFFFF & SETTINGS_WMASK) | (SETTINGS_RESET & ~SETTINGS_WMASK), v[1], v[2]};
      for (int i = 0; i < 3; i++) begin
         i_tsens_host_model.wr(8'(i + 1), v[i], 1'b1);
         i_tsens_host_model.rd(d);
         chk(d, e[i]);
      end
      chk(sw, e[0]);
      chk(lo, e[1]);
      chk(hi, e[2]);
   endtask
   task automatic t_temp();
      @(posedge CLK);
      rv <= 1'b1;
      rdat <= 16'hC8A5;
      @(posedge CLK);
      rv <= 1'b0;
      i_tsens_host_model.wr({6'h00, IDX_TEMPERATURE}, 16'h1111, 1'b1);
      i_tsens_host_model.rd(d);
      chk(d, 16'hC8A5);
      chk(hi, 16'h7FFE);
   endtask
   task automatic t_rates();
      int p[4];
      p = '{40, 20, 10, 5};
      for (int r = 0; r < 4; r++) begin
         i_tsens_host_model.wr(8'h01, 16'(r) << RATE_LSB, 1'b1);
         gap(n);
         gap(n);
         chk(16'(n), 16'(p[r]));
      end
   endtask
   task automatic t_reset();
      i_tsens_host_model.wr(8'h02, 16'h1234, 1'b1);
      chk(lo, 16'h1234);
      @(posedge CLK);
      RESET <= 1'b1;
      repeat (2) @(posedge CLK);
      RESET <= 1'b0;
      #1;
      chk({8'h00, ptr}, 16'h0000);
      chk(sw, SETTINGS_RESET);
      gap(n);
      chk(16'(n), 16'h0001);
      gap(n);
      chk(16'(n), 16'h000A);
   endtask
   initial begin
      RESET = 1'b1;
      rv = 1'b0;
      rdat = 16'h0000;
      error_cnt = 0;
      n_checks = 0;
      repeat (4) @(posedge CLK);
      RESET <= 1'b0;
      chk({8'h00, ptr}, 16'h0000);
      chk(sw, SETTINGS_RESET);
      gap(n);
      gap(n);
      chk(16'(n), 16'h000A);
      t_pointer();
      t_regs();
      t_temp();
      t_rates();
      t_reset();
      report_and_stop();
   end
endmodule
`default_nettype wire
